// *** logic/sensor_power_and_black_cal_regs.sv ***
// Sensor power, thermal diode and black-calibration register bank behind an APB slave.
`timescale 1ns/100ps
`default_nettype none

module sensor_power_and_black_cal_regs
  import sensor_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 resetn,
  // APB slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [sensor_cfg_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [sensor_cfg_pkg::DATA_W-1:0]    pwdata,
  output logic      [sensor_cfg_pkg::DATA_W-1:0]    prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // Thermal diode converter result, asynchronous to sys_clk
  input  wire logic [sensor_cfg_pkg::THERM_W-1:0]   therm_code,
  // Charge pump controls
  output logic                                      pump_xfer_en,
  output logic                                      pump_fd_en,
  output logic      [sensor_cfg_pkg::TRIM_W-1:0]    pump_xfer_trim,
  output logic      [sensor_cfg_pkg::TRIM_W-1:0]    pump_fd_trim,
  // Thermal diode control
  output logic                                      therm_diode_en,
  // Serial lane power, high means powered up
  output logic                                      lane_clk_up,
  output logic                                      lane_sync_up,
  output logic      [sensor_cfg_pkg::DATA_LANES-1:0] lane_data_up,
  // Black calibration and checksum seed
  output logic      [sensor_cfg_pkg::DARK_LEVEL_W-1:0] dark_target,
  output logic      [sensor_cfg_pkg::DARK_AVG_W-1:0]   dark_avg_log2,
  output logic                                      crc_seed_ones
);
  import sensor_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [REG_W-1:0]      regs_q [NREG];
  logic [REG_W-1:0]      regs_d [NREG];
  logic [DATA_LANES-1:0] lanes_q;
  logic [DATA_LANES-1:0] lanes_d;
  logic [THERM_W-1:0]    therm_s1_q;
  logic [THERM_W-1:0]    therm_s2_q;
  logic [THERM_W-1:0]    therm_s3_q;
  logic                  therm_steady;

  // APB answer registers.
  logic [DATA_W-1:0]     prdata_q;
  logic [DATA_W-1:0]     prdata_d;
  logic                  pready_q;
  logic                  pready_d;
  logic                  pslverr_q;
  logic                  pslverr_d;

  // Decode results.
  logic                  hit;
  logic [2:0]            slot;
  logic                  wr_fire;

  // Reset value and writable mask per slot, indexed by slot number.
  function automatic logic [REG_W-1:0] rst_val(input logic [2:0] s);
    unique case (s)
      3'h0: rst_val = RST_CHARGE_PUMP;
      3'h1: rst_val = RST_SPARE_A;
      3'h2: rst_val = RST_SPARE_B;
      3'h3: rst_val = RST_THERM_CTRL;
      3'h4: rst_val = RST_THERM_READ;
      3'h5: rst_val = RST_LANE_POWER;
      3'h6: rst_val = RST_DARK_CAL;
      3'h7: rst_val = RST_OUT_FORMAT;
    endcase
  endfunction

  function automatic logic [REG_W-1:0] wmask(input logic [2:0] s);
    unique case (s)
      3'h0: wmask = WMASK_CHARGE_PUMP;
      3'h1: wmask = WMASK_SPARE_A;
      3'h2: wmask = WMASK_SPARE_B;
      3'h3: wmask = WMASK_THERM_CTRL;
      3'h4: wmask = WMASK_THERM_READ;
      3'h5: wmask = WMASK_LANE_POWER;
      3'h6: wmask = WMASK_DARK_CAL;
      3'h7: wmask = WMASK_OUT_FORMAT;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Word-aligned accesses only; a misaligned or unknown address is an error.
  always_comb begin
    hit  = 1'b0;
    slot = 3'h0;
    if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0) begin
      hit = 1'b1;
      unique case (paddr[9:2])
        IDX_CHARGE_PUMP: slot = 3'(SLOT_CHARGE_PUMP);
        IDX_SPARE_A:     slot = 3'(SLOT_SPARE_A);
        IDX_SPARE_B:     slot = 3'(SLOT_SPARE_B);
        IDX_THERM_CTRL:  slot = 3'(SLOT_THERM_CTRL);
        IDX_THERM_READ:  slot = 3'(SLOT_THERM_READ);
        IDX_LANE_POWER:  slot = 3'(SLOT_LANE_POWER);
        IDX_DARK_CAL:    slot = 3'(SLOT_DARK_CAL);
        IDX_OUT_FORMAT:  slot = 3'(SLOT_OUT_FORMAT);
        default:         hit  = 1'b0;
      endcase
    end
  end

  // A write lands only at the edge where the master sees pready high.
  assign wr_fire = psel & penable & pready_q & pwrite & hit;

  // ----------------------------------------------------------------------
  // APB answer path
  // ----------------------------------------------------------------------
  // One wait state keeps prdata, pready and pslverr straight from flops.
  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d  = '0;
      pslverr_d = ~hit;
      if (hit && !pwrite) begin
        prdata_d = {{(DATA_W-REG_W){1'b0}}, regs_q[slot]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Only masked bits take the write, so undefined bits stay zero. Writes to the
  // read-only thermal reading are accepted without effect; its mask is empty.
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    lanes_d = lanes_q;
    if (wr_fire) begin
      // Bits outside the mask keep their stored value, so the read-only reading
      // and the always-zero bits cannot be disturbed by a host write.
      regs_d[slot] = (regs_q[slot] & ~wmask(slot))
                     | (pwdata[REG_W-1:0] & wmask(slot));
      if (slot == 3'(SLOT_LANE_POWER)) begin
        lanes_d = {DATA_LANES{pwdata[LANE_DATA_BIT]}};
      end
    end
    // The reading follows the diode only while it is powered; it freezes
    // otherwise so software sees the last valid conversion.
    if (regs_q[SLOT_THERM_CTRL][THERM_EN_BIT] && therm_steady) begin
      regs_d[SLOT_THERM_READ] = {{(REG_W-THERM_W){1'b0}}, therm_s3_q};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= rst_val(3'(i));
      end
      lanes_q <= '0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= regs_d[i];
      end
      lanes_q <= lanes_d;
    end
  end

  // ----------------------------------------------------------------------
  // Thermal code synchroniser
  // ----------------------------------------------------------------------
  // Multi-bit code is taken through two flops; a third copy lets the reading
  // move only when two successive samples agree, so a code caught mid-change
  // is never stored. The converter must still hold each code for some cycles.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      therm_s1_q <= '0;
      therm_s2_q <= '0;
      therm_s3_q <= '0;
    end else begin
      therm_s1_q <= therm_code;
      therm_s2_q <= therm_s1_q;
      therm_s3_q <= therm_s2_q;
    end
  end

  // Only the second stage and its copy are compared; the first may be metastable.
  assign therm_steady = (therm_s2_q == therm_s3_q);

  // ----------------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign pump_xfer_en   = regs_q[SLOT_CHARGE_PUMP][CP_XFER_EN_BIT];
  assign pump_fd_en     = regs_q[SLOT_CHARGE_PUMP][CP_FD_EN_BIT];
  assign pump_xfer_trim = regs_q[SLOT_CHARGE_PUMP][CP_XFER_TRIM_LSB +: TRIM_W];
  assign pump_fd_trim   = regs_q[SLOT_CHARGE_PUMP][CP_FD_TRIM_LSB +: TRIM_W];
  assign therm_diode_en = regs_q[SLOT_THERM_CTRL][THERM_EN_BIT];
  assign lane_clk_up    = regs_q[SLOT_LANE_POWER][LANE_CLK_BIT];
  assign lane_sync_up   = regs_q[SLOT_LANE_POWER][LANE_SYNC_BIT];
  assign lane_data_up   = lanes_q;
  assign dark_target    = regs_q[SLOT_DARK_CAL][DARK_LEVEL_LSB +: DARK_LEVEL_W];
  assign dark_avg_log2  = regs_q[SLOT_DARK_CAL][DARK_AVG_LSB +: DARK_AVG_W];
  assign crc_seed_ones  = regs_q[SLOT_DARK_CAL][CRC_SEED_BIT];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic in_reset_q;

  always_ff @(posedge sys_clk) begin
    in_reset_q <= ~resetn;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_CP_RESET: assert property (in_reset_q |-> pump_xfer_trim == 3'h2 && pump_fd_trim == 3'h1 && !pump_xfer_en)
    else $error("charge pump not at reset value");
  AST_FD_RESET: assert property (in_reset_q |-> !pump_fd_en)
    else $error("diffusion pump enabled after reset");
  AST_CP_WRITE: assert property (wr_fire && slot == 3'(SLOT_CHARGE_PUMP)
      |=> pump_xfer_en == $past(pwdata[0]) && pump_fd_en == $past(pwdata[1])
          && pump_fd_trim == $past(pwdata[14:12]))
    else $error("charge pump write not applied");
  AST_TRIM_HOLD: assert property (!wr_fire |=> $stable(pump_xfer_trim))
    else $error("transfer trim changed without a write");
  AST_THERM_FREEZE: assert property (!therm_diode_en |=> $stable(regs_q[SLOT_THERM_READ]))
    else $error("thermal reading moved while diode is off");
  AST_LANES_RESET: assert property (in_reset_q |-> !lane_clk_up && !lane_sync_up && lane_data_up == '0)
    else $error("lanes not powered down after reset");
  AST_SYNC_WRITE: assert property (wr_fire && slot == 3'(SLOT_LANE_POWER)
      |=> lane_sync_up == $past(pwdata[1]) && lane_clk_up == $past(pwdata[0]))
    else $error("lane power write not applied");
  AST_DATA_LANES: assert property (lane_data_up == '0 || lane_data_up == '1)
    else $error("data lanes not switched together");
  AST_DARK_RESET: assert property (in_reset_q |-> dark_target == 8'h08 && dark_avg_log2 == 3'h0)
    else $error("dark level fields not at reset value");
  AST_DARK_WRITE: assert property (wr_fire && slot == 3'(SLOT_DARK_CAL)
      |=> dark_avg_log2 == $past(pwdata[10:8]) && crc_seed_ones == $past(pwdata[15]))
    else $error("dark level write not applied");
  AST_SEED_RESET: assert property (in_reset_q |-> !crc_seed_ones)
    else $error("checksum seed not all zeros after reset");
  AST_ANSWER: assert property (psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("answer not one wait state");

  // Each written field must reach its pin at the completing edge itself.
  AST_ERR_DATA: assert property (pslverr |-> pready && prdata == '0)
    else $error("refused access returned data");
  AST_XFER_TRIM_WRITE: assert property (wr_fire && slot == 3'(SLOT_CHARGE_PUMP)
      |=> pump_xfer_trim == $past(pwdata[10:8]))
    else $error("transfer trim write not applied");
  AST_DIODE_WRITE: assert property (wr_fire && slot == 3'(SLOT_THERM_CTRL)
      |=> therm_diode_en == $past(pwdata[0]))
    else $error("diode enable write not applied");
  AST_THERM_FOLLOW: assert property (therm_diode_en && therm_steady
      |=> regs_q[SLOT_THERM_READ] == {{(REG_W-THERM_W){1'b0}}, $past(therm_s3_q)})
    else $error("thermal reading does not follow the diode");
  AST_DATA_WRITE: assert property (wr_fire && slot == 3'(SLOT_LANE_POWER)
      |=> lane_data_up == {DATA_LANES{$past(pwdata[LANE_DATA_BIT])}})
    else $error("data lanes did not take the write");
  AST_TARGET_WRITE: assert property (wr_fire && slot == 3'(SLOT_DARK_CAL)
      |=> dark_target == $past(pwdata[7:0]))
    else $error("dark target write not applied");

  COV_CP_WRITE:  cover property (wr_fire && slot == 3'(SLOT_CHARGE_PUMP));
  COV_SEED_ONES: cover property (crc_seed_ones && dark_avg_log2 == 3'h7);
  COV_LANES_UP:  cover property (lane_clk_up && lane_sync_up && lane_data_up == '1);
  COV_BAD_ADDR:  cover property (pready && pslverr);
  COV_THERM_RD:  cover property (pready && !pwrite && slot == 3'(SLOT_THERM_READ));

endmodule

`default_nettype wire

// *** logic/sensor_cfg_pkg.sv ***
// Package with the register map, field layout and reset values of the sensor config bank.
`default_nettype none

package sensor_cfg_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int NREG   = 8;

  // ----------------------------------------------------------------------
  // Printed register indices; the byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CHARGE_PUMP   = 8'h48;
  localparam logic [7:0] IDX_SPARE_A       = 8'h50;
  localparam logic [7:0] IDX_SPARE_B       = 8'h51;
  localparam logic [7:0] IDX_THERM_CTRL    = 8'h60;
  localparam logic [7:0] IDX_THERM_READ    = 8'h61;
  localparam logic [7:0] IDX_LANE_POWER    = 8'h70;
  localparam logic [7:0] IDX_DARK_CAL      = 8'h80;
  localparam logic [7:0] IDX_OUT_FORMAT    = 8'h81;

  // Storage slots, one per mapped register.
  localparam int SLOT_CHARGE_PUMP = 0;
  localparam int SLOT_SPARE_A     = 1;
  localparam int SLOT_SPARE_B     = 2;
  localparam int SLOT_THERM_CTRL  = 3;
  localparam int SLOT_THERM_READ  = 4;
  localparam int SLOT_LANE_POWER  = 5;
  localparam int SLOT_DARK_CAL    = 6;
  localparam int SLOT_OUT_FORMAT  = 7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_CHARGE_PUMP = 16'h1200;
  localparam logic [15:0] RST_SPARE_A     = 16'h0000;
  localparam logic [15:0] RST_SPARE_B     = 16'h0000;
  localparam logic [15:0] RST_THERM_CTRL  = 16'h0000;
  localparam logic [15:0] RST_THERM_READ  = 16'h0000;
  localparam logic [15:0] RST_LANE_POWER  = 16'h0000;
  localparam logic [15:0] RST_DARK_CAL    = 16'h4008;
  localparam logic [15:0] RST_OUT_FORMAT  = 16'hc001;

  // Writable bits of each register; all other bits read as zero, except the thermal reading in the low byte of its register.
  localparam logic [15:0] WMASK_CHARGE_PUMP = 16'h7703;
  localparam logic [15:0] WMASK_SPARE_A     = 16'h03ff;
  localparam logic [15:0] WMASK_SPARE_B     = 16'hffff;
  localparam logic [15:0] WMASK_THERM_CTRL  = 16'h0001;
  localparam logic [15:0] WMASK_THERM_READ  = 16'h0000;
  localparam logic [15:0] WMASK_LANE_POWER  = 16'h0007;
  localparam logic [15:0] WMASK_DARK_CAL    = 16'hffff;
  localparam logic [15:0] WMASK_OUT_FORMAT  = 16'hffff;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CP_XFER_EN_BIT   = 0;
  localparam int CP_FD_EN_BIT     = 1;
  localparam int CP_XFER_TRIM_LSB = 8;
  localparam int CP_FD_TRIM_LSB   = 12;
  localparam int TRIM_W           = 3;
  localparam int THERM_EN_BIT     = 0;
  localparam int THERM_W          = 8;
  localparam int LANE_CLK_BIT     = 0;
  localparam int LANE_SYNC_BIT    = 1;
  localparam int LANE_DATA_BIT    = 2;
  localparam int DATA_LANES       = 4;
  localparam int DARK_LEVEL_LSB   = 0;
  localparam int DARK_LEVEL_W     = 8;
  localparam int DARK_AVG_LSB     = 8;
  localparam int DARK_AVG_W       = 3;
  localparam int CRC_SEED_BIT     = 15;

endpackage

`default_nettype wire

// *** bench/apb_host_model.sv ***
// Host-side APB master model that programs the sensor configuration bank.
`timescale 1ns/100ps
`default_nettype none

module apb_host_model
  import sensor_cfg_pkg::*;
(
  // Clock
  input  wire logic                              sys_clk,
  // APB master side
  output var  logic                              psel,
  output var  logic                              penable,
  output var  logic                              pwrite,
  output var  logic [sensor_cfg_pkg::ADDR_W-1:0] paddr,
  output var  logic [sensor_cfg_pkg::DATA_W-1:0] pwdata,
  input  wire logic [sensor_cfg_pkg::DATA_W-1:0] prdata,
  input  wire logic                              pready,
  input  wire logic                              pslverr
);
  // ----------------------------------------------------------------------
  // Idle bus and transfer task
  // ----------------------------------------------------------------------
  // The bus is idle from time zero until the bench asks for a transfer.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // One transfer, held until pready is seen high at an edge; no wait count is assumed.
  // Address and data are inverted on release so a stale value never looks valid.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                      output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

`default_nettype wire

// *** bench/test_sensor_power_and_black_cal_regs.sv ***
// Self-checking testbench for the sensor power and black-calibration register bank.
`timescale 1ns/100ps
`default_nettype none

module test_sensor_power_and_black_cal_regs;
  import sensor_cfg_pkg::*;
  // ----------------------------------------------------------------------
  // Signals, shadow registers and stimulus tables
  // ----------------------------------------------------------------------
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [15:0] e;} row_t;
  logic                    sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic                    pump_xfer_en, pump_fd_en, therm_diode_en, lane_clk_up;
  logic                    lane_sync_up, crc_seed_ones;
  logic [ADDR_W-1:0]       paddr;
  logic [DATA_W-1:0]       pwdata, prdata, rd;
  logic [THERM_W-1:0]      therm_code;
  logic [TRIM_W-1:0]       pump_xfer_trim, pump_fd_trim;
  logic [DATA_LANES-1:0]   lane_data_up;
  logic [DARK_LEVEL_W-1:0] dark_target;
  logic [DARK_AVG_W-1:0]   dark_avg_log2;
  logic [15:0]             cp, th, lp, dc;
  logic [26:0]             outs;
  int                      num_errors = 0;
  int                      total_checks = 0;
  logic [11:0] radr [8] = '{12'h120, 12'h140, 12'h144, 12'h180, 12'h184, 12'h1c0, 12'h200, 12'h204};
  logic [15:0] rval [8] = '{RST_CHARGE_PUMP, RST_SPARE_A, RST_SPARE_B, RST_THERM_CTRL,
                            RST_THERM_READ, RST_LANE_POWER, RST_DARK_CAL, RST_OUT_FORMAT};
  logic [11:0] bad [4]  = '{12'h208, 12'h122, 12'h000, 12'h1c1};
  // Reserved fields are written with ones only in the all-ones charge-pump and thermal-control rows.
  row_t rows [14] = '{
    '{12'h120, 32'hffff_ffff, 16'h7703}, '{12'h120, 32'h0000_5601, 16'h5601},
    '{12'h120, 32'h0000_2302, 16'h2302}, '{12'h140, 32'h0000_0000, 16'h0000},
    '{12'h144, 32'h0000_0000, 16'h0000}, '{12'h180, 32'hffff_ffff, 16'h0001},
    '{12'h1c0, 32'h0000_0001, 16'h0001}, '{12'h1c0, 32'h0000_0002, 16'h0002},
    '{12'h1c0, 32'h0000_0004, 16'h0004}, '{12'h1c0, 32'h0000_0007, 16'h0007},
    '{12'h200, 32'h0000_c7ff, 16'hc7ff}, '{12'h200, 32'h0000_4508, 16'h4508},
    '{12'h204, 32'h0000_c001, 16'hc001}, '{12'h180, 32'h0000_0000, 16'h0000}};

  assign outs = {pump_fd_trim, pump_xfer_trim, pump_fd_en, pump_xfer_en, therm_diode_en,
                 lane_data_up, lane_sync_up, lane_clk_up, crc_seed_ones, dark_avg_log2, dark_target};

  // ----------------------------------------------------------------------
  // Design and host model
  // ----------------------------------------------------------------------
  sensor_power_and_black_cal_regs i_sensor_power_and_black_cal_regs (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .therm_code(therm_code), .pump_xfer_en(pump_xfer_en), .pump_fd_en(pump_fd_en),
    .pump_xfer_trim(pump_xfer_trim), .pump_fd_trim(pump_fd_trim),
    .therm_diode_en(therm_diode_en), .lane_clk_up(lane_clk_up), .lane_sync_up(lane_sync_up),
    .lane_data_up(lane_data_up), .dark_target(dark_target), .dark_avg_log2(dark_avg_log2),
    .crc_seed_ones(crc_seed_ones));

  apb_host_model i_apb_host_model (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------------
  // Compare and bus helpers
  // ----------------------------------------------------------------------
  // Expected pin values come from the shadow copies, never from the design.
  function automatic logic [26:0] exp_outs();
    return {cp[14:12], cp[10:8], cp[1], cp[0], th[0], {4{lp[2]}}, lp[1], lp[0],
            dc[15], dc[10:8], dc[7:0]};
  endfunction

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    i_apb_host_model.xfer(1'b0, a, '0, rd, err);
    check_word("read data", {16'h0, e}, rd);
    check_flag("slave error", 1'b0, err);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_apb_host_model.xfer(1'b1, a, d, rd, err);
    check_flag("write error", 1'b0, err);
  endtask

  // After a reset every register and every control pin is back at its default.
  task automatic check_reset();
    cp = RST_CHARGE_PUMP;
    th = RST_THERM_CTRL;
    lp = RST_LANE_POWER;
    dc = RST_DARK_CAL;
    for (int i = 0; i < 8; i++) rd_chk(radr[i], rval[i]);
    check_word("outputs", {5'h0, exp_outs()}, {5'h0, outs});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // The whole run needs well under a thousand cycles; a hang is cut short here.
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    therm_code = 8'h00;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    check_reset();
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      case (rows[i].a)
        12'h120: cp = rows[i].e;
        12'h180: th = rows[i].e;
        12'h1c0: lp = rows[i].e;
        12'h200: dc = rows[i].e;
        default: ;
      endcase
      rd_chk(rows[i].a, rows[i].e);
      check_word("outputs", {5'h0, exp_outs()}, {5'h0, outs});
    end
    $display("test table done");
    // Refused addresses, one of them aliasing the charge-pump word, must change nothing.
    foreach (bad[i]) begin
      i_apb_host_model.xfer(1'b1, bad[i], 32'hffff_ffff, rd, err);
      check_flag("write error", 1'b1, err);
      i_apb_host_model.xfer(1'b0, bad[i], '0, rd, err);
      check_word("error read data", 32'h0, rd);
      check_flag("read error", 1'b1, err);
    end
    check_word("outputs", {5'h0, exp_outs()}, {5'h0, outs});
    $display("test refused addresses done");
    // The reading follows the diode only while it is enabled.
    therm_code <= 8'h5a;
    wr(12'h180, 32'h1);
    repeat (6) @(posedge sys_clk);
    rd_chk(12'h184, 16'h005a);
    wr(12'h180, 32'h0);
    @(posedge sys_clk);
    therm_code <= 8'ha5;
    repeat (6) @(posedge sys_clk);
    rd_chk(12'h184, 16'h005a);
    $display("test thermal reading done");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    check_reset();
    $display("test second reset done");
    stop_test();
  end
endmodule

`default_nettype wire
